/* File: rtl/dpod_defs.vh */
// register offsets, field positions and timing constants for the option decoder
`ifndef DPOD_DEFS_VH
`define DPOD_DEFS_VH
`define DPOD_OFF_OPTIONS    4'h0
`define DPOD_OFF_SOURCE     4'h4
`define DPOD_OFF_COUNT      4'h8
`define DPOD_OFF_CONTROL    4'hc
`define DPOD_OFF_STATUS     4'h0
`define DPOD_SAM_BIT        0
`define DPOD_DAM_BIT        1
`define DPOD_SYNC_BIT       2
`define DPOD_STATIC_BIT     3
`define DPOD_FIFO_WIDTH_CODE_LSB       8
`define DPOD_FIFO_WIDTH_CODE_MSB       10
`define DPOD_CMODE_BIT      11
`define DPOD_CCODE_LSB      12
`define DPOD_CCODE_MSB      17
`define DPOD_OPT_WMASK      32'h0003_ff0f
`define DPOD_OPT_RESET      32'h0000_0000
`define DPOD_CNT_RESET      32'h0001_0001
`define DPOD_FIFO_WIDTH_CODE_MAX       3'h5
`define DPOD_CLK_MHZ        25
`define DPOD_XFER_NS        40
`define DPOD_XFER_CYC       ((`DPOD_XFER_NS * `DPOD_CLK_MHZ + 999) / 1000)
`endif

/* File: rtl/dpod_width_dec.v */
// fifo width code to byte wrap mask
`timescale 1ns/100ps
`include "dpod_defs.vh"
module dpod_width_dec
(
  input  wire [2:0] fifo_width_code, // width code
  output reg  [5:0] wrap_mask,       // byte wrap mask
  output reg        code_reserved    // code 6..7
);
  always @*
  begin
    code_reserved = (fifo_width_code > `DPOD_FIFO_WIDTH_CODE_MAX);
    // reserved codes fall back to the widest legal width, never beyond
    case (fifo_width_code)
      3'h0:    wrap_mask = 6'h00;
      3'h1:    wrap_mask = 6'h01;
      3'h2:    wrap_mask = 6'h03;
      3'h3:    wrap_mask = 6'h07;
      3'h4:    wrap_mask = 6'h0f;
      default: wrap_mask = 6'h1f;
    endcase
  end
endmodule // dpod_width_dec

/* File: rtl/dpod_addr_step.v */
// next address within an array: increment or wrap in a fifo window
`timescale 1ns/100ps
module dpod_addr_step
(
  input  wire [31:0] base_addr,  // array start address
  input  wire [31:0] cur_addr,   // current address
  input  wire        const_mode, // constant addressing
  input  wire [5:0]  wrap_mask,  // fifo width minus one
  output wire [31:0] next_addr   // next byte address
);
  wire [31:0] inc_addr;
  wire [31:0] mask32;
  assign inc_addr = cur_addr + 32'h0000_0001;
  assign mask32   = {26'h0000000, wrap_mask};
  // wrap keeps the upper bits of the array start, cycling the low bits
  assign next_addr = const_mode ?
                     ((base_addr & ~mask32) | (inc_addr & mask32)) :
                     inc_addr;
endmodule // dpod_addr_step

/* File: rtl/dpod_top.v */
// parameter set option decoder and byte mover for one channel
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`include "dpod_defs.vh"
module dpod_top
(
  input  wire        clk,          // 25 MHz clock
  input  wire        rst_n,        // async reset, active low
  input  wire        ce,           // clock enable
  input  wire        wb_cyc_i,     // wishbone cycle
  input  wire        wb_stb_i,     // wishbone strobe
  input  wire        wb_we_i,      // write enable
  input  wire [3:0]  wb_adr_i,     // byte address
  input  wire [3:0]  wb_sel_i,     // byte selects
  input  wire [31:0] wb_dat_i,     // write data
  output reg  [31:0] wb_dat_o,     // read data
  output reg         wb_ack_o,     // acknowledge
  input  wire        trig_event,   // sync event pulse
  output reg         req_valid,    // transfer request valid
  input  wire        req_ready,    // controller takes request
  output reg  [31:0] req_src,      // request source address
  output reg  [31:0] req_dst,      // request dest address
  input  wire        xfer_done,    // controller finished data
  output reg         done_pulse,   // completion strobe
  output reg  [5:0]  done_code,    // completion code
  output reg  [63:0] pending_reg   // pending bits
);
  localparam ST_IDLE = 2'h0;
  localparam ST_REQ  = 2'h1;
  localparam ST_WAIT = 2'h2;

  reg  [31:0] options_reg;
  reg  [31:0] source_reg;
  reg  [31:0] count_reg;
  reg  [31:0] dest_reg;
  reg  [1:0]  state_reg;
  reg  [31:0] src_base_reg;
  reg  [31:0] dst_base_reg;
  reg  [15:0] byte_cnt_reg;
  reg  [15:0] arr_cnt_reg;
  reg  [15:0] arr_left_reg;
  reg  [31:0] set_src_reg;
  reg         busy_reg;
  reg  [31:0] rd_next;
  reg  [63:0] pend_next;

  wire [5:0]  wrap_mask;
  wire        code_reserved;
  wire [31:0] src_step;
  wire [31:0] dst_step;
  wire        wb_req;
  wire        wb_wr;
  wire        source_addr_mode;
  wire        dest_addr_mode;
  wire [15:0] first_dim_bytes;
  wire [15:0] arrays_per_frame;
  wire        last_byte;
  wire        last_arr;
  wire        complete;
  wire [5:0]  completion_code;

  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer i;
    begin
      lane_merge = old_v;
      for (i = 0; i < 4; i = i + 1)
        if (sel[i])
          lane_merge[i*8 +: 8] = new_v[i*8 +: 8];
    end
  endfunction

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign source_addr_mode    = options_reg[`DPOD_SAM_BIT];
  assign dest_addr_mode    = options_reg[`DPOD_DAM_BIT];
  assign first_dim_bytes  = count_reg[15:0];
  assign arrays_per_frame = count_reg[31:16];
  assign completion_code  = options_reg[`DPOD_CCODE_MSB:`DPOD_CCODE_LSB];
  assign last_byte = (byte_cnt_reg == first_dim_bytes - 16'h0001);
  assign last_arr  = (arr_cnt_reg == arr_left_reg - 16'h0001);

  dpod_width_dec u_wdec
  (
    .fifo_width_code (options_reg[`DPOD_FIFO_WIDTH_CODE_MSB:`DPOD_FIFO_WIDTH_CODE_LSB]),
    .wrap_mask       (wrap_mask),
    .code_reserved   (code_reserved)
  );

  // width mask only matters when that side is in constant mode
  dpod_addr_step u_src_step
  (
    .base_addr  (src_base_reg),
    .cur_addr   (req_src),
    .const_mode (source_addr_mode),
    .wrap_mask  (wrap_mask),
    .next_addr  (src_step)
  );

  dpod_addr_step u_dst_step
  (
    .base_addr  (dst_base_reg),
    .cur_addr   (req_dst),
    .const_mode (dest_addr_mode),
    .wrap_mask  (wrap_mask),
    .next_addr  (dst_step)
  );

  // completion point: hand-over of last request or data finished
  assign complete = options_reg[`DPOD_CMODE_BIT] ?
                    (state_reg == ST_REQ && req_ready && last_byte &&
                     last_arr) :
                    (state_reg == ST_WAIT && xfer_done);

  always @*
  begin
    case (wb_adr_i)
      `DPOD_OFF_OPTIONS: rd_next = options_reg & `DPOD_OPT_WMASK;
      `DPOD_OFF_SOURCE:  rd_next = source_reg;
      `DPOD_OFF_COUNT:   rd_next = count_reg;
      `DPOD_OFF_CONTROL: rd_next = {29'h0, code_reserved, dest_addr_mode | source_addr_mode,
                                    busy_reg};
      default:           rd_next = 32'h0000_0000;
    endcase
  end

  always @*
  begin
    pend_next = pending_reg;
    if (complete)
      pend_next[completion_code] = 1'b1;
  end

  // completion outputs: one-cycle strobe, code held until the next one
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_pulse  <= 1'b0;
      done_code   <= 6'h00;
      pending_reg <= 64'h0;
    end
    else if (ce)
    begin
      done_pulse  <= complete;
      pending_reg <= pend_next;
      if (complete)
        done_code <= completion_code;
    end
  end

  // bus slave: ack one cycle after the request; read data is latched with
  // it and stands while ack is high
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce)
    begin
      wb_ack_o <= wb_req;
      if (wb_req)
        wb_dat_o <= rd_next;
    end
  end

  // writes land on the edge where the master samples ack, so a request
  // dropped before ack leaves the registers untouched
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      options_reg <= `DPOD_OPT_RESET;
    else if (ce && wb_wr && wb_adr_i == `DPOD_OFF_OPTIONS)
      options_reg <= lane_merge(options_reg, wb_dat_i, wb_sel_i) &
                     `DPOD_OPT_WMASK;
  end

  // a software write wins over the reload at the end of a transfer
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      source_reg <= 32'h0000_0000;
    else if (ce)
    begin
      if (wb_wr && wb_adr_i == `DPOD_OFF_SOURCE)
        source_reg <= lane_merge(source_reg, wb_dat_i, wb_sel_i);
      else if (state_reg == ST_WAIT && xfer_done &&
               !options_reg[`DPOD_STATIC_BIT])
        source_reg <= set_src_reg;
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_reg <= `DPOD_CNT_RESET;
    else if (ce && wb_wr && wb_adr_i == `DPOD_OFF_COUNT)
      count_reg <= lane_merge(count_reg, wb_dat_i, wb_sel_i);
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dest_reg <= 32'h0000_0000;
    else if (ce && wb_wr && wb_adr_i == `DPOD_OFF_CONTROL)
      dest_reg <= lane_merge(dest_reg, wb_dat_i, wb_sel_i);
  end

  // mover: one byte per request, walking arrays of the frame
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg    <= ST_IDLE;
      req_valid    <= 1'b0;
      req_src      <= 32'h0000_0000;
      req_dst      <= 32'h0000_0000;
      src_base_reg <= 32'h0000_0000;
      dst_base_reg <= 32'h0000_0000;
      byte_cnt_reg <= 16'h0000;
      arr_cnt_reg  <= 16'h0000;
      arr_left_reg <= 16'h0000;
      set_src_reg  <= 32'h0000_0000;
      busy_reg     <= 1'b0;
    end
    else if (ce)
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (trig_event && first_dim_bytes != 16'h0000)
          begin
            state_reg    <= ST_REQ;
            busy_reg     <= 1'b1;
            req_valid    <= 1'b1;
            req_src      <= source_reg;
            req_dst      <= dest_reg;
            src_base_reg <= source_reg;
            dst_base_reg <= dest_reg;
            byte_cnt_reg <= 16'h0000;
            arr_cnt_reg  <= 16'h0000;
            // one array per event, or all arrays of the frame
            arr_left_reg <= options_reg[`DPOD_SYNC_BIT] ?
                            arrays_per_frame : 16'h0001;
          end
        end
        ST_REQ:
        begin
          if (req_ready)
          begin
            if (last_byte)
            begin
              byte_cnt_reg <= 16'h0000;
              if (last_arr)
              begin
                req_valid <= 1'b0;
                state_reg <= ST_WAIT;
                // next array continues after this one
                set_src_reg <= src_step;
              end
              else
              begin
                arr_cnt_reg  <= arr_cnt_reg + 16'h0001;
                // wrap mode restarts each array at its base window
                req_src      <= source_addr_mode ? src_base_reg : src_step;
                req_dst      <= dest_addr_mode ? dst_base_reg : dst_step;
                src_base_reg <= source_addr_mode ? src_base_reg : src_step;
                dst_base_reg <= dest_addr_mode ? dst_base_reg : dst_step;
              end
            end
            else
            begin
              byte_cnt_reg <= byte_cnt_reg + 16'h0001;
              req_src      <= src_step;
              req_dst      <= dst_step;
            end
          end
        end
        ST_WAIT:
        begin
          // static sets keep source_reg; mode 1 already fired
          if (xfer_done)
          begin
            state_reg <= ST_IDLE;
            busy_reg  <= 1'b0;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // dpod_top

/* File: verif/dpod_top_sva.sv */
// port assertions for the option decoder
`timescale 1ns/100ps
module dpod_top_sva
(
  input wire        clk,        // clock
  input wire        rst_n,      // reset, active low
  input wire        ce,         // clock enable
  input wire        wb_cyc_i,   // cycle
  input wire        wb_stb_i,   // strobe
  input wire        wb_ack_o,   // ack
  input wire        req_valid,  // request valid
  input wire        req_ready,  // request taken
  input wire [31:0] req_src,    // source address
  input wire [31:0] req_dst,    // dest address
  input wire        xfer_done,  // data moved
  input wire        done_pulse, // completion
  input wire [5:0]  done_code,  // code
  input wire [63:0] pending_reg // pending bits
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce
    |=> wb_ack_o) else $error("ack missing");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_req_held: assert property (req_valid && !req_ready |=> req_valid
    && $stable(req_src) && $stable(req_dst)) else $error("request dropped");
  a_done_single: assert property (done_pulse |=> !done_pulse)
    else $error("done too long");
  a_done_cause: assert property (done_pulse
    |-> $past(xfer_done) || $past(req_valid && req_ready))
    else $error("done without cause");
  a_pending_code: assert property (done_pulse |-> pending_reg[done_code])
    else $error("pending bit missing");
  a_pending_sticky: assert property (1'b1
    |=> (pending_reg & $past(pending_reg)) == $past(pending_reg))
    else $error("pending bit lost");
endmodule // dpod_top_sva
bind dpod_top dpod_top_sva dpod_top_sva_inst
(
  .clk(clk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .req_valid(req_valid),
  .req_ready(req_ready), .req_src(req_src), .req_dst(req_dst),
  .xfer_done(xfer_done), .done_pulse(done_pulse), .done_code(done_code),
  .pending_reg(pending_reg)
);

/* File: verif/dpod_xfer_model.sv */
// transfer controller model: takes byte requests, reports data moved
`timescale 1ns/100ps
module dpod_xfer_model
(
  input  wire        clk,       // clock
  input  wire        rst_n,     // reset, active low
  input  wire        req_valid, // request valid
  input  wire [31:0] req_src,   // source address
  input  wire [31:0] req_dst,   // dest address
  output reg         req_ready, // request taken
  output reg         xfer_done  // all data moved
);
  logic [31:0] src_q[$];
  logic [31:0] dst_q[$];
  int          lag;
  // lag only runs once requests stop, so data lands after the last byte
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_ready <= 1'b0;
      xfer_done <= 1'b0;
      lag       <= 0;
    end
    else
    begin
      xfer_done <= (lag == 1) && !req_valid;
      if (lag > 0 && !req_valid)
        lag <= lag - 1;
      if (req_valid && req_ready)
      begin
        src_q.push_back(req_src);
        dst_q.push_back(req_dst);
        lag <= 4 + $urandom % 4;
      end
      req_ready <= ($urandom % 3) != 0;
    end
  end
endmodule // dpod_xfer_model

/* File: verif/tb.sv */
// self-checking bench for the option decoder
`timescale 1ns/100ps
`include "dpod_defs.vh"
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic        trig_event = 1'b0;
  logic        ce = 1'b1;
  wire  [31:0] wb_dat_o, req_src, req_dst;
  wire         wb_ack_o, req_valid, req_ready, xfer_done, done_pulse;
  wire  [5:0]  done_code;
  wire  [63:0] pending_reg;
  logic [31:0] rd, channel_options_word, src, dst, a;
  int          fail_count = 0, cmp_count = 0, cyc_cnt = 0, xd_count = 0;
  int          it, k, n, nb, na, xb;
  dpod_top dpod_top_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .trig_event(trig_event), .req_valid(req_valid), .req_ready(req_ready),
    .req_src(req_src), .req_dst(req_dst), .xfer_done(xfer_done),
    .done_pulse(done_pulse), .done_code(done_code),
    .pending_reg(pending_reg));
  dpod_xfer_model dpod_xfer_model_inst (.clk(clk), .rst_n(rst_n),
    .req_valid(req_valid), .req_src(req_src), .req_dst(req_dst),
    .req_ready(req_ready), .xfer_done(xfer_done));
  always #20 clk = ~clk;
  always @(posedge clk)
    if (xfer_done === 1'b1)
      xd_count <= xd_count + 1;
  always @(posedge clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000)
    begin
      fail_count++;
      stop_test;
    end
  end
  task automatic stop_test;
    if (fail_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [63:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we  <= w;
    adr <= ad;
    wd  <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0;
  endtask
  // expected byte address k of a transfer with nb bytes per array
  function automatic logic [31:0] ea(input logic [31:0] b, input logic c,
                                     input logic [2:0] w, input int k, nb);
    int m;
    m = (w > 3'h5) ? 32 : 1 << w;
    return c ? (b & ~(m - 1)) | ((b + k % nb) & (m - 1)) : b + k;
  endfunction
  initial
  begin
    void'($urandom(32'ha77c));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 4'h0, 0);
    check("opt reset", 0, rd);
    bus(1'b0, 4'h8, 0);
    check("count reset", `DPOD_CNT_RESET, rd);
    bus(1'b0, 4'h1, 0);
    check("unmapped", 0, rd);
    ce <= 1'b0;
    trig_event <= 1'b1;
    repeat (3) @(posedge clk);
    check("frozen", 0, {req_valid, done_pulse});
    trig_event <= 1'b0;
    ce <= 1'b1;
    for (it = 0; it < 24; it++)
    begin
      channel_options_word = $urandom & `DPOD_OPT_WMASK;
      channel_options_word[10:8] = it % 8;
      nb = 1 + $urandom % 5;
      na = 1 + $urandom % 3;
      src = $urandom;
      dst = $urandom;
      bus(1'b1, 4'h0, channel_options_word | ($urandom & ~`DPOD_OPT_WMASK));
      bus(1'b1, 4'h4, src);
      bus(1'b1, 4'h8, 32'(na << 16 | nb));
      bus(1'b1, 4'hc, dst);
      bus(1'b0, 4'h0, 0);
      check("opt", channel_options_word, rd);
      bus(1'b0, 4'h4, 0);
      check("src", src, rd);
      bus(1'b0, 4'hc, 0);
      check("status", {channel_options_word[10:8] > 3'h5, channel_options_word[1] | channel_options_word[0], 1'b0}, rd[2:0]);
      xb = xd_count;
      trig_event <= 1'b1;
      @(posedge clk);
      trig_event <= 1'b0;
      do @(posedge clk); while (done_pulse !== 1'b1);
      check("early", !channel_options_word[11], xd_count - xb);
      check("code", channel_options_word[17:12], done_code);
      check("pend", 1, pending_reg[channel_options_word[17:12]]);
      while (xd_count == xb)
        @(posedge clk);
      n = channel_options_word[2] ? nb * na : nb;
      check("bytes", n, dpod_xfer_model_inst.src_q.size());
      for (k = 0; k < n; k++)
      begin
        a = dpod_xfer_model_inst.src_q.pop_front();
        check("src a", ea(src, channel_options_word[0], channel_options_word[10:8], k, nb), a);
        a = dpod_xfer_model_inst.dst_q.pop_front();
        check("dst a", ea(dst, channel_options_word[1], channel_options_word[10:8], k, nb), a);
      end
      a = channel_options_word[0] ? ea(src, 1'b1, channel_options_word[10:8], nb, nb + 1) : src + n;
      bus(1'b0, 4'h4, 0);
      if (channel_options_word[3])
        check("static", src, rd);
      else
        check("update", a, rd);
    end
    stop_test;
  end
endmodule // tb
